// ### design/dsr_top.sv
// dual eight stage serial shift register with pin level clocks
// assumes clock pins, data pins and selectors come from outside this
// clock domain; a snapshot stream is offered to on-chip logic via a fifo
`timescale 1ns/100ps
`default_nettype none
`include "dsr_params.svh"

module dsr_top #(
   parameter int STAGES = `DSR_STAGES,
   parameter int FIFO_DEPTH = `DSR_FIFO_DEPTH
) (
   input wire logic clock, // system clock, 50 MHz
   input wire logic rst, // async reset, active high
   input wire logic master_clear_n, // async clear of all stages, low active
   input wire logic shared_clk, // clock common to both registers
   input wire logic [1:0] own_clk, // one own clock per register
   input wire logic [1:0] input_selector, // per register data select
   input wire logic [1:0] serial_in_low_sel, // data taken while select low
   input wire logic [1:0] serial_in_high_sel, // data taken while select high
   output logic [1:0] serial_out, // last stage, true
   output logic [1:0] serial_out_n, // last stage, complemented
   output logic snap_valid, // a snapshot word is waiting
   input wire logic snap_ready, // reader takes the snapshot
   output var dsr_pkg::dsr_snap_t snap_data, // {shifted, reg1, reg0}
   output logic snap_overflow // sticky: a snapshot was lost, fifo full
);
   import dsr_pkg::*;

   dsr_state_s st_r;
   dsr_state_s st_nxt;
   logic fifo_in_ready;
   logic [`DSR_NUM_REGS-1:0] eff_clk;
   logic [`DSR_NUM_REGS-1:0] rise;
   logic [`DSR_NUM_REGS-1:0] sel_data;

   // effective clock per register from the synchronised pins; either
   // pin held high masks the other, held low passes it through
   always_comb begin
      for (int i = 0; i < `DSR_NUM_REGS; i++) begin
         eff_clk[i] = st_r.clk_s2[`DSR_CLK_SHARED]
                      | st_r.clk_s2[i]; // see (R2) (R7)
         rise[i] = eff_clk[i] & ~st_r.eff_prev[i]; // see (R4)
         // two input selector in front of each register
         sel_data[i] = st_r.sel_s2[i] ? st_r.dhi_s2[i]
                                      : st_r.dlo_s2[i]; // see (R8)
      end
   end

   // next state: synchronisers, master latches, stages, snapshot push
   always_comb begin
      st_nxt = st_r;
      // first stage of each synchroniser feeds only the second
      st_nxt.clk_s1 = {shared_clk, own_clk};
      st_nxt.clk_s2 = st_r.clk_s1;
      st_nxt.sel_s1 = input_selector;
      st_nxt.sel_s2 = st_r.sel_s1;
      st_nxt.dlo_s1 = serial_in_low_sel;
      st_nxt.dlo_s2 = st_r.dlo_s1;
      st_nxt.dhi_s1 = serial_in_high_sel;
      st_nxt.dhi_s2 = st_r.dhi_s1;
      st_nxt.eff_prev = eff_clk;
      st_nxt.push = 1'b0;
      for (int i = 0; i < `DSR_NUM_REGS; i++) begin
         if (!eff_clk[i]) begin
            // clock low: master follows the data, stages hold
            st_nxt.master[i] = sel_data[i]; // see (R3) (R6)
         end
         // master frozen while clock high; stages move only on the rise
         if (rise[i]) begin
            // the frozen master enters stage 0, the rest move one onward
            st_nxt.stages[i] = {st_r.stages[i][STAGES-2:0],
                                st_r.master[i]}; // see (R4) (R12)
            st_nxt.push = 1'b1;
         end // see (R5)
         st_nxt.ser_out[i] = st_nxt.stages[i][STAGES-1]; // see (R9)
         st_nxt.ser_out_n[i] = ~st_nxt.stages[i][STAGES-1]; // see (R9)
      end
      // one snapshot per cycle with a shift, both registers in one word
      st_nxt.push_word = {rise, st_nxt.stages[1], st_nxt.stages[0]};
      // a snapshot refused by a full fifo is lost, and that is flagged;
      // the shifters cannot be stalled since the pins own their clocks
      if (st_r.push && !fifo_in_ready) begin
         st_nxt.overflow = 1'b1;
      end
   end

   // one register for all state; master clear empties both registers and
   // parks the clock synchronisers high so a release with a clock pin high
   // gives no false edge: the next shift needs a low then a rise
   always_ff @(posedge clock or posedge rst or negedge master_clear_n) begin
      if (rst || !master_clear_n) begin // see (R10)
         st_r.clk_s1 <= `DSR_CLK_SYNC_RST;
         st_r.clk_s2 <= `DSR_CLK_SYNC_RST;
         st_r.sel_s1 <= `DSR_ZERO2;
         st_r.sel_s2 <= `DSR_ZERO2;
         st_r.dlo_s1 <= `DSR_ZERO2;
         st_r.dlo_s2 <= `DSR_ZERO2;
         st_r.dhi_s1 <= `DSR_ZERO2;
         st_r.dhi_s2 <= `DSR_ZERO2;
         st_r.eff_prev <= `DSR_ONES2;
         st_r.master <= `DSR_ZERO2;
         st_r.stages[0] <= `DSR_STAGE_RST; // see (R1)
         st_r.stages[1] <= `DSR_STAGE_RST; // see (R1)
         st_r.ser_out <= `DSR_ZERO2;
         st_r.ser_out_n <= `DSR_ONES2;
         st_r.push <= `DSR_ZERO1;
         st_r.push_word <= '0;
         st_r.overflow <= `DSR_ZERO1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // snapshot buffer; its reader may stall it until it really fills
   dsr_fifo #(
      .WIDTH(`DSR_SNAP_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(st_r.push),
      .in_ready(fifo_in_ready),
      .in_data(st_r.push_word),
      .out_valid(snap_valid),
      .out_ready(snap_ready),
      .out_data(snap_data)
   );

   assign serial_out = st_r.ser_out;
   assign serial_out_n = st_r.ser_out_n;
   assign snap_overflow = st_r.overflow;

endmodule
`default_nettype wire

// ### pkg/dsr_params.svh
// constants for the dual serial shift register block
// assumes it is included by the package and by every design file using it
//
// Function
// (R1) two independent 8-stage registers; one shared clock, one own clock each
// (R2) each register's effective clock is shared clock OR its own clock
// (R3) both clocks low: stages hold, serial input flows into master latch
// (R4) effective clock rising: master frozen, its content moves into the stages
// (R5) while any clock of a register stays high, master and stages hold
// (R6) last high clock falling: stages keep state, master accepts data again
// (R7) each clock input enables the other: low lets it clock, high stops it
// (R8) serial input is low-select data when selector low, else high-select data
// (R9) each register drives its last stage true and complemented
// (R10) master clear low asynchronously zeroes all sixteen stages at once
// (R11) driver may use clocks as two clocks, two enables, or common enable
// (R12) each effective rising edge shifts stages toward last, loading first
`ifndef DSR_PARAMS_SVH
`define DSR_PARAMS_SVH

// register geometry
`define DSR_NUM_REGS 2
`define DSR_STAGES 8
// three clock pins: index of the shared one, own ones are 0 and 1
`define DSR_CLK_PINS 3
`define DSR_CLK_SHARED 2
// snapshot fifo depth between the shifters and the reader
`define DSR_FIFO_DEPTH 4
// snapshot word: shift flags above both registers' stages
`define DSR_SNAP_W 18
// reset values
`define DSR_STAGE_RST 8'h00
`define DSR_CLK_SYNC_RST 3'h7
`define DSR_ZERO2 2'h0
`define DSR_ONES2 2'h3
`define DSR_ZERO1 1'h0

`endif

// ### pkg/dsr_pkg.sv
// types shared by the dual serial shift register block
// assumes dsr_params.svh is on the include path
`include "dsr_params.svh"

package dsr_pkg;

   typedef logic [`DSR_STAGES-1:0] dsr_stage_t;
   typedef logic [`DSR_SNAP_W-1:0] dsr_snap_t;

   // whole state of the top module, registered in one process
   typedef struct packed {
      logic [`DSR_CLK_PINS-1:0] clk_s1;
      logic [`DSR_CLK_PINS-1:0] clk_s2;
      logic [`DSR_NUM_REGS-1:0] sel_s1;
      logic [`DSR_NUM_REGS-1:0] sel_s2;
      logic [`DSR_NUM_REGS-1:0] dlo_s1;
      logic [`DSR_NUM_REGS-1:0] dlo_s2;
      logic [`DSR_NUM_REGS-1:0] dhi_s1;
      logic [`DSR_NUM_REGS-1:0] dhi_s2;
      logic [`DSR_NUM_REGS-1:0] eff_prev;
      logic [`DSR_NUM_REGS-1:0] master;
      logic [`DSR_NUM_REGS-1:0][`DSR_STAGES-1:0] stages;
      logic [`DSR_NUM_REGS-1:0] ser_out;
      logic [`DSR_NUM_REGS-1:0] ser_out_n;
      logic push;
      dsr_snap_t push_word;
      logic overflow;
   } dsr_state_s;

endpackage

// ### design/dsr_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an active high asynchronous reset
`timescale 1ns/100ps
`default_nettype none

module dsr_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 4
) (
   input wire logic clock, // system clock
   input wire logic rst, // async reset, active high
   input wire logic in_valid, // writer offers a word
   output logic in_ready, // room for a word
   input wire logic [WIDTH-1:0] in_data, // word offered
   output logic out_valid, // a word is waiting
   input wire logic out_ready, // reader takes the word
   output logic [WIDTH-1:0] out_data // oldest word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [CW-1:0] count;
      logic full;
      logic empty;
      logic valid;
      logic [WIDTH-1:0] head;
   } dsr_fifo_s;

   dsr_fifo_s st_r;
   dsr_fifo_s st_nxt;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic do_wr;
   logic do_rd;

   // flags come from registers so neither side sees a combinational loop
   assign in_ready = ~st_r.full;
   assign out_valid = st_r.valid;
   assign out_data = st_r.head;
   assign do_wr = in_valid & ~st_r.full;
   assign do_rd = out_ready & ~st_r.empty;

   // pointer and level bookkeeping
   always_comb begin
      st_nxt = st_r;
      if (do_wr) begin
         st_nxt.wr_ptr = (int'(st_r.wr_ptr) == DEPTH - 1) ? '0 :
                         AW'(st_r.wr_ptr + 1'b1);
      end
      if (do_rd) begin
         st_nxt.rd_ptr = (int'(st_r.rd_ptr) == DEPTH - 1) ? '0 :
                         AW'(st_r.rd_ptr + 1'b1);
      end
      if (do_wr && !do_rd) begin
         st_nxt.count = CW'(st_r.count + 1'b1);
      end else if (do_rd && !do_wr) begin
         st_nxt.count = CW'(st_r.count - 1'b1);
      end
      st_nxt.full = (int'(st_nxt.count) == DEPTH);
      st_nxt.empty = (st_nxt.count == '0);
      st_nxt.valid = ~st_nxt.empty;
      // head word is held in a flop so the reader sees no storage mux;
      // a word written into the slot that becomes the head bypasses it
      if (do_wr && (st_r.wr_ptr == st_nxt.rd_ptr)) begin
         st_nxt.head = in_data;
      end else begin
         st_nxt.head = mem_r[st_nxt.rd_ptr];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= '{wr_ptr: '0, rd_ptr: '0, count: '0, full: 1'b0,
                   empty: 1'b1, valid: 1'b0, head: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // storage has no reset: it is only read behind the empty flag
   always_ff @(posedge clock) begin
      if (do_wr) begin
         mem_r[st_r.wr_ptr] <= in_data;
      end
   end

endmodule
`default_nettype wire

// ### testbench/dsr_pin_driver.sv
// model of the logic around the register pins: data and three clocks
// assumes one pulse at a time, timed off the system clock
`timescale 1ns/100ps
`default_nettype none
module dsr_pin_driver (
   input wire logic clock, // system clock
   output logic shared_clk, // common clock pin
   output logic [1:0] own_clk, // own clock pins
   output logic [1:0] input_selector, // data selects
   output logic [1:0] serial_in_low_sel, // data while select low
   output logic [1:0] serial_in_high_sel // data while select high
);
   // parked with every clock high so nothing shifts between pulses
   initial begin
      shared_clk = 1'b1;
      own_clk = 2'b11;
      input_selector = 2'b00;
      serial_in_low_sel = 2'b00;
      serial_in_high_sel = 2'b00;
   end
   // md 0 shared clock with own enables, 1 own clocks, 2 shared inhibit
   task automatic pulse(input logic [1:0] md, mk, input logic [5:0] d,
         input int n);
      @(posedge clock);
      input_selector <= d[5:4];
      serial_in_high_sel <= d[3:2];
      serial_in_low_sel <= d[1:0];
      shared_clk <= (md == 2'd2);
      own_clk <= ~mk; // low lets a register clock
      repeat (n) @(posedge clock);
      shared_clk <= (md != 2'd1);
      own_clk <= (md == 2'd0) ? ~mk : 2'b11;
      // data turns over with the rise; only the older value may count
      serial_in_high_sel <= ~d[3:2];
      serial_in_low_sel <= ~d[1:0];
      repeat (n) @(posedge clock);
      shared_clk <= 1'b1;
      own_clk <= 2'b11;
      repeat (n) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ### testbench/dsr_top_properties.sv
// port checks for the dual shift register top
// assumes it is bound into dsr_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "dsr_params.svh"
module dsr_top_properties #(
   parameter int STAGES = 8, parameter int FIFO_DEPTH = 4
) (
   input wire logic clock, // system clock
   input wire logic rst, // reset, high
   input wire logic master_clear_n, // clear, low
   input wire logic shared_clk, // common clock pin
   input wire logic [1:0] own_clk, // own clock pins
   input wire logic [1:0] serial_out, // last stages
   input wire logic [1:0] serial_out_n, // their inverse
   input wire logic snap_valid, // word waiting
   input wire logic snap_ready, // word taken
   input wire logic [`DSR_SNAP_W-1:0] snap_data, // head word
   input wire logic snap_overflow // word lost
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // pins quiet long enough that any earlier shift has landed
   sequence s_high; (shared_clk && master_clear_n) [*6]; endsequence
   sequence s_low;
      (!shared_clk && !own_clk && master_clear_n) [*5];
   endsequence
   a_out_inverse: assert property (serial_out_n == ~serial_out)
      else $error("outputs not complementary");
   a_clear_zero: assert property (!master_clear_n |-> !serial_out)
      else $error("clear left a stage set");
   a_high_holds: assert property (s_high |-> $stable(serial_out))
      else $error("shift while a clock held high");
   a_low_holds: assert property (s_low |-> $stable(serial_out))
      else $error("shift while all clocks low");
   a_shift_snaps: assert property (
      master_clear_n && $changed(serial_out) |-> ##[0:3] snap_valid)
      else $error("shift without snapshot");
   a_snap_who: assert property (
      $rose(snap_valid) |-> |snap_data[`DSR_SNAP_W-1:`DSR_SNAP_W-2])
      else $error("snapshot names no register");
   a_stall_keeps: assert property (
      snap_valid && !snap_ready |=> snap_valid && $stable(snap_data))
      else $error("stalled word changed");
   a_ovf_sticky: assert property (
      snap_overflow ##1 master_clear_n |-> snap_overflow)
      else $error("overflow flag dropped");
endmodule
bind dsr_top dsr_top_properties #(.STAGES(STAGES), .FIFO_DEPTH(FIFO_DEPTH))
   u_props (.clock, .rst, .master_clear_n, .shared_clk, .own_clk,
   .serial_out, .serial_out_n, .snap_valid, .snap_ready, .snap_data,
   .snap_overflow);
`default_nettype wire

// ### testbench/dsr_top_tb.sv
// self-checking bench for the dual shift register top
// assumes the pin driver model and the checker compile alongside
`timescale 1ns/100ps
`default_nettype none
`include "dsr_params.svh"
module dsr_top_tb;
   logic clock, rst, master_clear_n, shared_clk, snap_valid, snap_ready;
   logic snap_overflow, rd_hold;
   logic [1:0] own_clk, input_selector, serial_in_low_sel;
   logic [1:0] serial_in_high_sel, serial_out, serial_out_n;
   logic [`DSR_SNAP_W-1:0] snap_data;
   logic [`DSR_SNAP_W-1:0] notes[$];
   logic [7:0] m0, m1; // reference stages, bit 0 first
   int bad_count, num_checks, seed, i;
   dsr_top uut (.clock, .rst, .master_clear_n, .shared_clk, .own_clk,
      .input_selector, .serial_in_low_sel, .serial_in_high_sel,
      .serial_out, .serial_out_n, .snap_valid, .snap_ready, .snap_data,
      .snap_overflow);
   dsr_pin_driver far (.clock, .shared_clk, .own_clk, .input_selector,
      .serial_in_low_sel, .serial_in_high_sel);
   // 50 MHz system clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic chk(input logic [`DSR_SNAP_W-1:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one pin pulse; the reference shifts and notes the snapshot
   task automatic shift(input logic [1:0] md, mk, input int n, input bit nt);
      logic [5:0] d;
      logic [1:0] b, hit;
      logic [3:0] ex;
      d = 6'($random(seed));
      b = (d[5:4] & d[3:2]) | (~d[5:4] & d[1:0]);
      hit = (md == 2'd2) ? 2'b00 : mk; // shared held high blocks
      if (hit[0]) m0 = {m0[6:0], b[0]};
      if (hit[1]) m1 = {m1[6:0], b[1]};
      if (nt && hit != 2'b00) notes.push_back({hit, m1, m0});
      far.pulse(md, mk, d, n);
      repeat (2) @(negedge clock);
      ex = {~m1[7], ~m0[7], m1[7], m0[7]};
      chk(18'({serial_out_n, serial_out}), 18'(ex));
   endtask
   // waits, bounded, until every noted snapshot was taken
   task automatic drain;
      for (int k = 0; k < 400 &&
           (notes.size() > 0 || snap_valid !== 1'b0); k++)
         @(negedge clock);
      chk(18'(notes.size()), 18'h0_0000);
   endtask
   // reader with random stalls; each taken word meets its oldest note
   always @(posedge clock) begin
      if (snap_valid && snap_ready && notes.size() > 0)
         chk(snap_data, notes.pop_front());
      else if (snap_valid && snap_ready)
         chk(snap_data, 'x); // no snapshot was due
      snap_ready <= rd_hold ? 1'b0 : 1'($random(seed));
   end
   // reset, every clock use, a full fifo, then a clear in mid-run
   initial begin
      seed = 32'h8479;
      rst = 1'b1;
      master_clear_n = 1'b1;
      rd_hold = 1'b0;
      snap_ready = 1'b0;
      m0 = 8'h00;
      m1 = 8'h00;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 30; i++)
         shift(2'(i % 3), 2'(i % 4), 2 + i % 5, 1'b1);
      drain;
      rd_hold <= 1'b1;
      for (i = 0; i < 6; i++)
         shift(2'd1, 2'b11, 3, i < `DSR_FIFO_DEPTH);
      chk(18'(snap_overflow), 18'h0_0001);
      rd_hold <= 1'b0;
      drain;
      // clear is applied on a rising edge like every other input
      @(posedge clock);
      master_clear_n <= 1'b0;
      @(negedge clock);
      chk(18'({snap_overflow, serial_out}), 18'h0_0000);
      m0 = 8'h00;
      m1 = 8'h00;
      @(posedge clock);
      master_clear_n <= 1'b1;
      for (i = 0; i < 4; i++)
         shift(2'd0, 2'b11, 3, 1'b1);
      drain;
      give_verdict;
   end
   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #(20 * 30000);
      bad_count++;
      give_verdict;
   end
endmodule
`default_nettype wire
